// ===== src/rsv_cfg.svh
// register offsets, field positions, reset values and frame constants for rsv
// assumes a 12-bit apb byte address and 32-bit data
`ifndef RSV_CFG_SVH
`define RSV_CFG_SVH

`define RSV_OFF_CTRL     12'h000
`define RSV_OFF_OWN_LO   12'h004
`define RSV_OFF_OWN_HI   12'h008
`define RSV_OFF_LAST     12'h00C
`define RSV_OFF_STATUS   12'h010
`define RSV_OFF_MASK     12'h014

`define RSV_CTRL_VLAN    0
`define RSV_CTRL_JUMBO   1
`define RSV_CTRL_LTDIS   2
`define RSV_CTRL_PROMISC 3
`define RSV_CTRL_FLOW    4
`define RSV_CTRL_RST     5'h10

`define RSV_EV_GOOD      0
`define RSV_EV_BAD       1
`define RSV_EV_PAUSE     2
`define RSV_EV_OVERSIZE  3

`define RSV_TYPE_CTRL    16'h8808
`define RSV_TYPE_VLAN    16'h8100
`define RSV_OPC_PAUSE    16'h0001
`define RSV_CTRL_MCAST   48'h0180C2000001
`define RSV_TAG_BYTES    14'h0004
`define RSV_LEN_MAX      14'h3FFF

`endif

// ===== src/rsv_pkg.sv
// types shared by the receive statistics vector block
// assumes rsv_cfg.svh supplies the numeric constants
package rsv_pkg;

  // per-frame statistics word, bit 27 down to bit 0
  typedef struct packed {
    logic        addr_match;
    logic        align_err;
    logic        lt_err;
    logic        bad_opcode;
    logic        pause_done;
    logic        rsvd;
    logic        tagged_frame_flag;
    logic        oversize_frame_flag;
    logic        ctrl_type;
    logic [13:0] length;
    logic        mcast;
    logic        bcast;
    logic        checksum_error_flag;
    logic        bad;
    logic        good;
  } rsv_word_t;

  // byte stream and end-of-frame verdicts from the receive engine
  typedef struct packed {
    logic [7:0] data;
    logic       byte_en;
    logic       frame_end;
    logic       fcs_bad;
    logic       code_err;
    logic       align_err;
    logic       lt_err;
    logic       other_err;
    logic       addr_pass;
  } rsv_rx_t;

  typedef enum logic {RSV_SER_IDLE, RSV_SER_SHIFT} rsv_ser_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [4:0]  ctrl;
    logic [47:0] own_addr;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        irq;
    rsv_word_t   last;
    logic [13:0] idx;
    logic        da_mc;
    logic        da_bc;
    logic        da_ctl;
    logic        da_own;
    logic [15:0] lt;
    logic [15:0] opc;
    rsv_word_t   shift;
    logic [1:0]  slice_cnt;
    rsv_ser_t    ser;
    logic [6:0]  slice_out;
    logic        strobe;
    logic        byte_pulse;
  } rsv_state_t;

endpackage

// ===== src/rsv_stats.sv
// receive statistics vector: parses each frame's header, builds the 28-bit word,
// sends it out as four 7-bit slices and exposes control and status over apb
// assumes the receive engine runs on pclk and marks frame end one cycle after
// the last fcs byte, with its verdict inputs valid in that cycle
`timescale 1ns/100ps
`include "rsv_cfg.svh"

// How it works
// R1 - pause bit set for clean control frame, matching address, pause opcode, acted on
// R2 - tagged bit set for vlan type field while vlan handling is enabled
// R3 - oversize bit set beyond standard maximum, only while jumbo acceptance is off
// R4 - control-type bit set whenever type field holds the control value
// R5 - byte count in bits 18 to 5, saturating at its maximum
// R6 - multicast bit from the group bit of the destination address
// R7 - broadcast bit when destination address is all ones
// R8 - checksum error bit on bad fcs or line error codes
// R9 - bad bit when the frame had any error
// R10 - good bit when the frame was free of errors
// R11 - with type checks disabled, a type error alone still counts good
// R12 - no statistics counters inside; client logic accumulates statistics
// R13 - word held internally and multiplexed onto a 7-bit bus after each frame
// R14 - strobe high exactly while slices are on the 7-bit bus
// R15 - byte-seen pulse for each frame byte from address through fcs
// R16 - address-match bit from filter result, forced high in promiscuous mode
// R17 - four slices, low slice first, on consecutive cycles under strobe
// R18 - reserved bit 22 always driven as zero
module rsv_stats
  import rsv_pkg::*;
#(
  parameter int MAX_STD_LEN = 1518
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  rsv_rx_t          rx,
  output logic      [6:0]  rx_stats_slice_out,
  output logic             rx_stats_strobe,
  output logic             rx_byte_seen_pulse,
  output logic             irq
);

  // the limit must fit the 14-bit length field and cover a minimum frame
  if (MAX_STD_LEN < 64 || MAX_STD_LEN > 16379) begin : g_bad_len
    $error("rsv_stats: MAX_STD_LEN out of range");
  end

  localparam logic [13:0] STD_LIM = 14'(MAX_STD_LEN);

  rsv_state_t s_q;
  rsv_state_t s_d;

  // destination byte i of a value stored first-byte-in-top order
  function automatic logic [7:0] msb_byte(input logic [47:0] v, input logic [2:0] i);
    logic [5:0] sh;
    sh = 6'(8 * (5 - int'(i)));
    return 8'(v >> sh);
  endfunction

  // destination byte i of own address, first byte held in the low bits
  function automatic logic [7:0] lsb_byte(input logic [47:0] v, input logic [2:0] i);
    logic [5:0] sh;
    sh = 6'(8 * int'(i));
    return 8'(v >> sh);
  endfunction

  logic        wr_go;
  logic        vlan_en;
  logic        jumbo_en;
  logic        lt_dis;
  logic        promisc;
  logic        flow_en;
  logic        is_ctrl;
  logic        is_tag;
  logic        over;
  logic        err_any;
  logic [13:0] lim;
  logic [3:0]  ev;
  rsv_word_t   w;

  always_comb begin
    vlan_en  = s_q.ctrl[`RSV_CTRL_VLAN];
    jumbo_en = s_q.ctrl[`RSV_CTRL_JUMBO];
    lt_dis   = s_q.ctrl[`RSV_CTRL_LTDIS];
    promisc  = s_q.ctrl[`RSV_CTRL_PROMISC];
    flow_en  = s_q.ctrl[`RSV_CTRL_FLOW];
  end

  // frame verdict; only meaningful in the frame_end cycle
  always_comb begin
    is_ctrl = (s_q.lt == `RSV_TYPE_CTRL);
    // R2 tag needs enable
    is_tag  = vlan_en && (s_q.lt == `RSV_TYPE_VLAN);
    lim     = STD_LIM + (is_tag ? `RSV_TAG_BYTES : 14'h0000);
    // R3 jumbo disables oversize
    over    = !jumbo_en && (s_q.idx > lim);
    // R11 type error gated
    err_any = rx.fcs_bad || rx.code_err || rx.align_err || rx.other_err
              || over || (rx.lt_err && !lt_dis);
    w                     = '0;
    // R16 filter or promiscuous
    w.addr_match          = promisc || rx.addr_pass;
    w.align_err           = rx.align_err;
    w.lt_err              = rx.lt_err && !lt_dis;
    w.bad_opcode          = !err_any && is_ctrl && (s_q.opc != `RSV_OPC_PAUSE);
    // R1 pause acted upon
    w.pause_done          = !err_any && is_ctrl && (s_q.da_ctl || s_q.da_own)
                            && (s_q.opc == `RSV_OPC_PAUSE) && flow_en;
    // R18 reserved bit zero
    w.rsvd                = 1'b0;
    w.tagged_frame_flag   = is_tag;
    w.oversize_frame_flag = over;
    // R4 control type regardless
    w.ctrl_type           = is_ctrl;
    // R5 saturated length
    w.length              = s_q.idx;
    // R6 group bit
    w.mcast               = s_q.da_mc;
    // R7 all-ones address
    w.bcast               = s_q.da_bc;
    // R8 fcs or code error
    w.checksum_error_flag = rx.fcs_bad || rx.code_err;
    // R9 any error
    w.bad                 = err_any;
    // R10 error free
    w.good                = !err_any;
    ev = '0;
    ev[`RSV_EV_GOOD]     = rx.frame_end && !err_any;
    ev[`RSV_EV_BAD]      = rx.frame_end && err_any;
    ev[`RSV_EV_PAUSE]    = rx.frame_end && w.pause_done;
    ev[`RSV_EV_OVERSIZE] = rx.frame_end && over;
  end

  // whole next state; registers, parser, serializer and bus slave
  always_comb begin
    s_d   = s_q;
    wr_go = psel && penable && s_q.pready && pwrite;

    // R15 byte seen pulse
    s_d.byte_pulse = rx.byte_en;

    // apb: decode in setup, answer in the first access cycle, no wait states
    s_d.pready = 1'b0;
    if (psel && !penable) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata  = '0;
      if (paddr == `RSV_OFF_CTRL) begin
        s_d.prdata = 32'(s_q.ctrl);
      end else if (paddr == `RSV_OFF_OWN_LO) begin
        s_d.prdata = s_q.own_addr[31:0];
      end else if (paddr == `RSV_OFF_OWN_HI) begin
        s_d.prdata = 32'(s_q.own_addr[47:32]);
      end else if (paddr == `RSV_OFF_LAST) begin
        s_d.prdata = 32'(s_q.last);
      end else if (paddr == `RSV_OFF_STATUS) begin
        s_d.prdata = 32'(s_q.status);
      end else if (paddr == `RSV_OFF_MASK) begin
        s_d.prdata = 32'(s_q.mask);
      end else begin
        s_d.pslverr = 1'b1;
      end
    end else if (psel && penable && s_q.pready) begin
      s_d.prdata  = '0;
      s_d.pslverr = 1'b0;
    end

    if (wr_go) begin
      if (paddr == `RSV_OFF_CTRL) begin
        s_d.ctrl = pwdata[4:0];
      end else if (paddr == `RSV_OFF_OWN_LO) begin
        s_d.own_addr[31:0] = pwdata;
      end else if (paddr == `RSV_OFF_OWN_HI) begin
        s_d.own_addr[47:32] = pwdata[15:0];
      end else if (paddr == `RSV_OFF_STATUS) begin
        s_d.status = s_q.status & ~pwdata[3:0];
      end else if (paddr == `RSV_OFF_MASK) begin
        s_d.mask = pwdata[3:0];
      end
    end
    // events applied after the clear so a same-cycle event is never lost
    s_d.status = s_d.status | ev;
    s_d.irq    = |(s_d.status & s_d.mask);

    // header parse; position counter doubles as the length count
    if (rx.byte_en) begin
      // R5 count saturates
      if (s_q.idx != `RSV_LEN_MAX) begin
        s_d.idx = s_q.idx + 14'h0001;
      end
      if (s_q.idx == 14'h0000) begin
        s_d.da_mc  = rx.data[0];
        s_d.da_bc  = (rx.data == 8'hFF);
        s_d.da_ctl = (rx.data == msb_byte(`RSV_CTRL_MCAST, 3'h0));
        s_d.da_own = (rx.data == lsb_byte(s_q.own_addr, 3'h0));
      end else if (s_q.idx < 14'h0006) begin
        s_d.da_bc  = s_q.da_bc && (rx.data == 8'hFF);
        s_d.da_ctl = s_q.da_ctl && (rx.data == msb_byte(`RSV_CTRL_MCAST, s_q.idx[2:0]));
        s_d.da_own = s_q.da_own && (rx.data == lsb_byte(s_q.own_addr, s_q.idx[2:0]));
      end else if (s_q.idx == 14'h000C) begin
        s_d.lt[15:8] = rx.data;
      end else if (s_q.idx == 14'h000D) begin
        s_d.lt[7:0] = rx.data;
      end else if (s_q.idx == 14'h000E) begin
        s_d.opc[15:8] = rx.data;
      end else if (s_q.idx == 14'h000F) begin
        s_d.opc[7:0] = rx.data;
      end
    end

    // R17 four slices, low first
    s_d.strobe = 1'b0;
    case (s_q.ser)
      RSV_SER_IDLE: begin
        s_d.slice_out = '0;
      end
      RSV_SER_SHIFT: begin
        // R14 strobe marks slices
        s_d.strobe = 1'b1;
        case (s_q.slice_cnt)
          2'd0: s_d.slice_out = s_q.shift[6:0];
          2'd1: s_d.slice_out = s_q.shift[13:7];
          2'd2: s_d.slice_out = s_q.shift[20:14];
          default: s_d.slice_out = s_q.shift[27:21];
        endcase
        s_d.slice_cnt = s_q.slice_cnt + 2'd1;
        if (s_q.slice_cnt == 2'd3) begin
          s_d.ser = RSV_SER_IDLE;
        end
      end
      default: begin
        s_d.ser = RSV_SER_IDLE;
      end
    endcase

    // R13 latch word, start mux
    if (rx.frame_end) begin
      s_d.last      = w;
      s_d.shift     = w;
      s_d.slice_cnt = 2'd0;
      s_d.ser       = RSV_SER_SHIFT;
      s_d.idx       = '0;
      s_d.lt        = '0;
      s_d.opc       = '0;
      s_d.da_mc     = 1'b0;
      s_d.da_bc     = 1'b0;
      s_d.da_ctl    = 1'b0;
      s_d.da_own    = 1'b0;
    end
  end

  // R12 state holds no statistics counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.ctrl <= `RSV_CTRL_RST;
      s_q.ser  <= RSV_SER_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign rx_stats_slice_out = s_q.slice_out;
  assign rx_stats_strobe    = s_q.strobe;
  assign rx_byte_seen_pulse = s_q.byte_pulse;
  assign irq                = s_q.irq;

endmodule

// ===== tb/rsv_stats_chk.sv
// timing and flag checks on the rsv_stats ports
// assumes one pclk domain and a bench that spaces frame ends apart
`timescale 1ns/100ps
module rsv_stats_chk
  import rsv_pkg::*;
#(
  parameter int MAX_STD_LEN = 1518
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire rsv_rx_t     rx,
  input wire logic [6:0]  rx_stats_slice_out,
  input wire logic        rx_stats_strobe,
  input wire logic        rx_byte_seen_pulse,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // four slices under one unbroken strobe
  sequence s_slices;
    rx_stats_strobe [*4];
  endsequence
  // no new frame end in the cycle the serializer arms or while the four slices go out
  sequence s_quiet;
    !rx.frame_end [*5];
  endsequence

  a_byte_pulse_set: assert property (rx.byte_en |=> rx_byte_seen_pulse)
    else $error("byte pulse missing");
  a_byte_pulse_clr: assert property (!rx.byte_en |=> !rx_byte_seen_pulse)
    else $error("byte pulse without byte");
  // the serializer arms on the frame end edge, so the first slice shows one cycle later
  a_strobe_run: assert property (rx.frame_end |=> ##1 s_slices)
    else $error("strobe not four cycles");
  a_strobe_stop: assert property (rx.frame_end ##1 s_quiet |=> !rx_stats_strobe)
    else $error("strobe too long");
  a_strobe_cause: assert property ($rose(rx_stats_strobe) |-> $past(rx.frame_end, 2))
    else $error("strobe without frame end");
  a_slice_idle: assert property (!rx_stats_strobe |-> rx_stats_slice_out == 7'h00)
    else $error("slice bus not zero");
  a_rsvd_zero: assert property (rx.frame_end |-> ##5 !rx_stats_slice_out[1])
    else $error("reserved bit set");
  a_fcs_flag: assert property (rx.frame_end && (rx.fcs_bad || rx.code_err)
    |-> ##2 rx_stats_slice_out[2:0] == 3'h6) else $error("checksum flags wrong");
  a_addr_flag: assert property (rx.frame_end && rx.addr_pass
    |-> ##5 rx_stats_slice_out[6]) else $error("address match flag missing");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
endmodule

bind rsv_stats rsv_stats_chk #(.MAX_STD_LEN(MAX_STD_LEN)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx(rx), .rx_stats_slice_out(rx_stats_slice_out), .rx_stats_strobe(rx_stats_strobe),
  .rx_byte_seen_pulse(rx_byte_seen_pulse), .irq(irq));

// ===== tb/rsv_client_model.sv
// client logic that rebuilds the stats word and counts frame bytes
// assumes slices arrive low first on consecutive strobed cycles
`timescale 1ns/100ps
module rsv_client_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [6:0]  slice,
  input  wire logic        strobe,
  input  wire logic        byte_pulse,
  output logic      [27:0] word,
  output logic      [15:0] nbytes,
  output logic             done
);
  logic [1:0]  idx;
  logic [20:0] acc;
  logic [15:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {idx, acc, cnt, word, nbytes, done} <= '0;
    end else begin
      done <= 1'b0;
      if (byte_pulse) cnt <= cnt + 16'h0001;
      if (!strobe) idx <= 2'h0;
      else begin
        idx <= idx + 2'h1;
        acc <= {slice, acc[20:7]};
        if (idx == 2'h3) begin
          word <= {slice, acc};
          nbytes <= cnt;
          cnt <= 16'h0000;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== tb/rsv_stats_tb_top.sv
// random frames and register traffic against rsv_stats
// assumes the client model rebuilds each word; checker is bound separately
`timescale 1ns/100ps
`include "rsv_cfg.svh"
module rsv_stats_tb_top
  import rsv_pkg::*;
;
  localparam int ML = 100; // short maximum keeps oversize frames cheap
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        strobe, bpulse, mdone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  slice;
  logic [27:0] mword, w;
  logic [15:0] mbytes;
  logic [4:0]  ctrl;
  logic [3:0]  mask;
  logic [7:0]  hdr[16];
  logic [7:0]  e;
  logic [47:0] own_b;
  rsv_rx_t     rx;
  int          failures, compares, n, k;

  rsv_stats #(.MAX_STD_LEN(ML)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx(rx), .rx_stats_slice_out(slice),
    .rx_stats_strobe(strobe), .rx_byte_seen_pulse(bpulse), .irq(irq));
  rsv_client_model cm (.pclk(pclk), .presetn(presetn), .slice(slice), .strobe(strobe),
    .byte_pulse(bpulse), .word(mword), .nbytes(mbytes), .done(mdone));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int c = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (pready !== 1'b1) begin
      failures++;
      give_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic send(input int len);
    int c = 0;
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      rx.data <= i < 16 ? hdr[i] : 8'($urandom);
      rx.byte_en <= 1'b1;
    end
    @(posedge pclk);
    rx.byte_en <= 1'b0;
    rx.frame_end <= 1'b1;
    {rx.addr_pass, rx.other_err, rx.lt_err, rx.align_err, rx.code_err, rx.fcs_bad} <= e[5:0];
    @(posedge pclk);
    rx.frame_end <= 1'b0;
    while (mdone !== 1'b1 && c < 20) begin
      @(posedge pclk);
      c++;
    end
    if (mdone !== 1'b1) begin
      failures++;
      give_verdict;
    end
  endtask

  // random header; destination, type and opcode picked from the awkward cases
  task automatic make_hdr;
    int d = $urandom_range(3);
    for (int i = 0; i < 16; i++) hdr[i] = 8'($urandom);
    for (int i = 0; i < 6; i++)
      hdr[i] = d == 0 ? 8'hFF : d == 1 ? 8'(`RSV_CTRL_MCAST >> (40 - 8 * i)) :
               d == 2 ? own_b[47 - 8 * i -: 8] : hdr[i];
    d = $urandom_range(2);
    if (d == 0) {hdr[12], hdr[13]} = `RSV_TYPE_CTRL;
    if (d == 1) {hdr[12], hdr[13]} = `RSV_TYPE_VLAN;
    if ($urandom_range(1)) {hdr[14], hdr[15]} = `RSV_OPC_PAUSE;
  endtask

  // expected word; e = {addr_pass, other, lt, align, code, fcs}
  function automatic logic [27:0] exp_word(input int len);
    logic [47:0] da;
    logic [15:0] lt, op;
    logic        tg, ov, ct, lte, er;
    logic [27:0] x;
    da = {hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]};
    lt = {hdr[12], hdr[13]};
    op = {hdr[14], hdr[15]};
    tg = lt == `RSV_TYPE_VLAN && ctrl[0];
    ov = !ctrl[1] && len > ML + (tg ? 4 : 0);
    ct = lt == `RSV_TYPE_CTRL;
    // type error ignored when checks off
    lte = e[3] && !ctrl[2];
    er = e[0] | e[1] | e[2] | e[4] | ov | lte;
    x = '0;
    x[27] = e[5] | ctrl[3];
    x[26] = e[2];
    x[25] = lte;
    x[24] = !er && ct && op != `RSV_OPC_PAUSE;
    x[23] = !er && ct && op == `RSV_OPC_PAUSE && ctrl[4] && (da == `RSV_CTRL_MCAST || da == own_b);
    x[21] = tg;
    x[20] = ov;
    x[19] = ct;
    x[18:5] = len > 16383 ? `RSV_LEN_MAX : 14'(len);
    x[4] = hdr[0][0];
    x[3] = da == 48'hFFFFFFFFFFFF;
    x[2] = e[0] | e[1];
    x[1] = er;
    x[0] = !er;
    return x;
  endfunction

  task automatic frame(input int len);
    send(len);
    w = exp_word(len);
    chk(32'(mword), 32'(w));
    chk(32'(mbytes), 32'(len));
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx, failures, compares} = '0;
    void'($urandom(15));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `RSV_OFF_CTRL, 0);
    chk(rd, 32'h10);
    apb(0, `RSV_OFF_MASK, 0);
    chk(rd, 32'h0);
    apb(1, 12'h020, 32'hFFFFFFFF);
    chk(32'(err), 32'h1);
    own_b = {8'h02, 24'($urandom), 16'($urandom)};
    apb(1, `RSV_OFF_OWN_LO, 32'({<<8{own_b}}));
    apb(1, `RSV_OFF_OWN_HI, {16'h0000, 16'({<<8{own_b}} >> 32)});
    apb(0, `RSV_OFF_OWN_HI, 0);
    chk(rd, {16'h0000, 16'({<<8{own_b}} >> 32)});
    $display("register test done");
    for (int t = 0; t < 40; t++) begin
      ctrl = t < 32 ? 5'(t) : 5'($urandom);
      mask = 4'($urandom);
      e = $urandom_range(1) ? 8'($urandom) & 8'h20 : 8'($urandom);
      n = t % 3 == 0 ? ML + (t / 3) % 6 : $urandom_range(60, 140);
      make_hdr;
      apb(1, `RSV_OFF_CTRL, 32'(ctrl));
      apb(1, `RSV_OFF_MASK, 32'(mask));
      apb(1, `RSV_OFF_STATUS, 32'hF);
      frame(n);
      apb(0, `RSV_OFF_LAST, 0);
      chk(rd, 32'(w));
      apb(0, `RSV_OFF_STATUS, 0);
      chk(rd, {28'h0, w[20], w[23], w[1], w[0]});
      chk(32'(irq), 32'(|({w[20], w[23], w[1], w[0]} & mask)));
      $display("frame test %0d done", t);
    end
    ctrl = 5'h02;
    e = 8'h00;
    make_hdr;
    apb(1, `RSV_OFF_CTRL, 32'(ctrl));
    frame(16400);
    $display("saturation test done");
    give_verdict;
  end
endmodule
